// >>> src/utec_pkg.sv
// Purpose: Shared constants and types for the USB token and endpoint control block
// Assumes: 32-bit Avalon-MM register access, byte addresses, one word per register
// Notes: Endpoint control words sit at a base plus four times the endpoint number
package utec_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_FRAME_HIGH = 8'h00;
    localparam logic [7:0] ADDR_TOKEN = 8'h04;
    localparam logic [7:0] ADDR_EP_BASE = 8'h40;
    localparam logic [7:0] ADDR_EP_MASK = 8'hC3;

    // Endpoint control field positions
    localparam int FIELD_LOW_SPEED_DIRECT = 7;
    localparam int FIELD_RETRY_DIS = 6;
    localparam int FIELD_CON_DIS = 4;
    localparam int FIELD_RX_EN = 3;
    localparam int FIELD_TX_EN = 2;
    localparam int FIELD_STALL = 1;
    localparam int FIELD_HSHK = 0;

    // Token register and frame fields
    localparam int TOK_PID_LSB = 4;
    localparam int TOK_EP_LSB = 0;
    localparam int FRAME_HIGH_LSB = 8;

    // Reset values
    localparam logic [7:0] RST_TOKEN = 8'h00;
    localparam logic [3:0] RST_EP = 4'h0;
    localparam logic [2:0] RST_FRAME_HIGH = 3'h0;
    localparam logic [31:0] RST_READDATA = 32'h0000_0000;

    // Token type codes
    localparam logic [3:0] PID_OUT = 4'h1;
    localparam logic [3:0] PID_IN = 4'h9;
    localparam logic [3:0] PID_SETUP = 4'hD;

    // Transaction results reported by the link
    localparam logic [1:0] RES_ACK = 2'h0;
    localparam logic [1:0] RES_NAK = 2'h1;
    localparam logic [1:0] RES_STALL = 2'h2;
    localparam logic [1:0] RES_ERROR = 2'h3;

    // Avalon-MM response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECODEERROR = 2'h3;

    typedef struct packed {
        logic [3:0] pid;
        logic [3:0] ep;
        logic low_speed_direct;
        logic use_preamble;
    } utec_token_type;

    typedef struct packed {
        logic valid;
        logic [3:0] pid;
        logic [3:0] ep;
    } utec_rx_token_type;

    typedef struct packed {
        logic valid;
        logic [3:0] ep;
        logic accept;
        logic handshake;
        logic stalled;
    } utec_verdict_type;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_FETCH = 3'b010,
        BUS_DONE = 3'b100
    } utec_bus_state_type;

    typedef enum logic [1:0] {
        TOK_IDLE = 2'b01,
        TOK_WAIT = 2'b10
    } utec_tok_state_type;

endpackage

// >>> src/utec_ep_store.sv
// Purpose: Endpoint control storage, one write port and two registered read ports
// Assumes: Synchronous active-low reset clears every word
// Notes: Read data appear one clock after the address
`timescale 1ns/1ps
module utec_ep_store #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr_a,
    output logic [WIDTH-1:0] o_rdata_a,
    input wire logic [AW-1:0] i_raddr_b,
    output logic [WIDTH-1:0] o_rdata_b
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= utec_pkg::RST_EP;
            end
            o_rdata_a <= utec_pkg::RST_EP;
            o_rdata_b <= utec_pkg::RST_EP;
        end else begin
            if (i_we) begin
                mem[i_waddr] <= i_wdata;
            end
            o_rdata_a <= mem[i_raddr_a];
            o_rdata_b <= mem[i_raddr_b];
        end
    end

endmodule

// >>> src/utec_core.sv
// Purpose: Token issue, frame number capture and endpoint control for a USB module
// Assumes: Link logic on the same clock; Avalon-MM register slave
// Notes: Every bus access takes three cycles; stall flags are set by hardware only
//
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps

// How it works
// - Frame upper bits captured on each SOF
// - Token types: OUT 0001, IN 1001, SETUP 1101
// - Endpoint 0 host: low-speed direct or preamble
// - Endpoint 0 host: NAK retry unless disabled
// - Both directions enabled: bit 4 blocks SETUP
// - Bit 3 enables receive, bit 2 transmit
// - Bit 1 reads one once endpoint stalled
// - Bit 0 enables handshake packets
// - Unused upper bits always read zero
module utec_core (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic [1:0] o_avs_response,
    input wire logic i_host_mode,
    input wire logic i_sof_valid,
    input wire logic [10:0] i_sof_frame,
    output logic o_tok_valid,
    output utec_pkg::utec_token_type o_tok,
    input wire logic i_tok_done,
    input wire logic [1:0] i_tok_result,
    input wire utec_pkg::utec_rx_token_type i_rx_tok,
    input wire logic i_stall_valid,
    input wire logic [3:0] i_stall_ep,
    output utec_pkg::utec_verdict_type o_verdict,
    output logic o_tok_busy
);

    function automatic logic is_ep_addr(input logic [7:0] a);
        return (a & utec_pkg::ADDR_EP_MASK) == utec_pkg::ADDR_EP_BASE;
    endfunction

    function automatic logic [3:0] ep_of_addr(input logic [7:0] a);
        return a[5:2];
    endfunction

    utec_pkg::utec_bus_state_type bus_state;
    utec_pkg::utec_bus_state_type next_bus_state;
    utec_pkg::utec_tok_state_type tok_state;

    logic [2:0] frame_high;
    logic [7:0] tok_reg;
    logic ep0_low_speed_direct;
    logic ep0_retry_dis;
    logic [15:0] stall;
    logic [15:0] next_stall;
    logic [3:0] mem_rd_a;
    logic [3:0] mem_rd_b;
    logic rx_valid_d;
    logic [3:0] rx_pid_d;
    logic [3:0] rx_ep_d;

    wire bus_req = i_avs_read | i_avs_write;
    wire hit_frame = i_avs_address == utec_pkg::ADDR_FRAME_HIGH;
    wire hit_tok = i_avs_address == utec_pkg::ADDR_TOKEN;
    wire hit_ep = is_ep_addr(i_avs_address);
    wire [3:0] bus_ep = ep_of_addr(i_avs_address);
    wire hit_any = hit_frame | hit_tok | hit_ep;
    wire commit = (bus_state == utec_pkg::BUS_DONE) && i_avs_write && i_avs_byteenable[0];
    wire [7:0] wd = i_avs_writedata[7:0];
    wire ep_write = commit && hit_ep;
    wire tok_write = commit && hit_tok;
    wire launch = tok_write && i_host_mode && (tok_state == utec_pkg::TOK_IDLE);

    // Endpoint word as stored: condis, rx_en, tx_en, handshake
    wire [3:0] ep_wdata = {wd[utec_pkg::FIELD_CON_DIS], wd[utec_pkg::FIELD_RX_EN],
                           wd[utec_pkg::FIELD_TX_EN], wd[utec_pkg::FIELD_HSHK]};

    // Low speed and retry bits exist for endpoint 0 only
    wire ep0_sel = bus_ep == 4'h0;
    wire [7:0] ep_rbyte = {ep0_sel & ep0_low_speed_direct, ep0_sel & ep0_retry_dis, 1'b0,
                           mem_rd_a[3], mem_rd_a[2], mem_rd_a[1], stall[bus_ep],
                           mem_rd_a[0]};

    // Upper bits padded with zero for every register
    wire [31:0] rd_mux = hit_frame ? {29'h0000_0000, frame_high} :
                         hit_tok ? {24'h00_0000, tok_reg} :
                         hit_ep ? {24'h00_0000, ep_rbyte} :
                         utec_pkg::RST_READDATA;

    wire hw_host_stall = (tok_state == utec_pkg::TOK_WAIT) && i_tok_done &&
                         (i_tok_result == utec_pkg::RES_STALL);
    wire nak_retry = (tok_state == utec_pkg::TOK_WAIT) && i_tok_done &&
                     (i_tok_result == utec_pkg::RES_NAK) && !ep0_retry_dis;

    // Device side verdict from the looked up endpoint word
    wire v_con_dis = mem_rd_b[3];
    wire v_rx_en = mem_rd_b[2];
    wire v_tx_en = mem_rd_b[1];
    wire v_hshk = mem_rd_b[0];
    wire setup_blocked = v_rx_en && v_tx_en && v_con_dis;
    wire pid_ok = (rx_pid_d == utec_pkg::PID_OUT) ? v_rx_en :
                  (rx_pid_d == utec_pkg::PID_IN) ? v_tx_en :
                  (rx_pid_d == utec_pkg::PID_SETUP) ? (v_rx_en && !setup_blocked) :
                  1'b0;
    wire v_accept = pid_ok && !stall[rx_ep_d];

    utec_ep_store u_store (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_we(ep_write),
        .i_waddr(bus_ep),
        .i_wdata(ep_wdata),
        .i_raddr_a(bus_ep),
        .o_rdata_a(mem_rd_a),
        .i_raddr_b(i_rx_tok.ep),
        .o_rdata_b(mem_rd_b)
    );

    always_comb begin
        next_bus_state = bus_state;
        case (bus_state)
            utec_pkg::BUS_IDLE: begin
                if (bus_req) begin
                    next_bus_state = utec_pkg::BUS_FETCH;
                end
            end
            utec_pkg::BUS_FETCH: next_bus_state = utec_pkg::BUS_DONE;
            utec_pkg::BUS_DONE: next_bus_state = utec_pkg::BUS_IDLE;
            default: next_bus_state = utec_pkg::BUS_IDLE;
        endcase
    end

    // Bus slave: read data and response stand for the one cycle waitrequest is low
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            bus_state <= utec_pkg::BUS_IDLE;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= utec_pkg::RST_READDATA;
            o_avs_response <= utec_pkg::RESP_OKAY;
        end else begin
            bus_state <= next_bus_state;
            o_avs_waitrequest <= next_bus_state != utec_pkg::BUS_DONE;
            if (next_bus_state == utec_pkg::BUS_DONE) begin
                o_avs_readdata <= i_avs_read ? rd_mux : utec_pkg::RST_READDATA;
                o_avs_response <= hit_any ? utec_pkg::RESP_OKAY
                                          : utec_pkg::RESP_DECODEERROR;
            end else begin
                o_avs_readdata <= utec_pkg::RST_READDATA;
                o_avs_response <= utec_pkg::RESP_OKAY;
            end
        end
    end

    // Software registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tok_reg <= utec_pkg::RST_TOKEN;
            ep0_low_speed_direct <= 1'b0;
            ep0_retry_dis <= 1'b0;
        end else begin
            if (tok_write) begin
                tok_reg <= wd;
            end
            if (ep_write && ep0_sel) begin
                ep0_low_speed_direct <= wd[utec_pkg::FIELD_LOW_SPEED_DIRECT];
                ep0_retry_dis <= wd[utec_pkg::FIELD_RETRY_DIS];
            end
        end
    end

    // Frame number upper bits refresh on every SOF
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            frame_high <= utec_pkg::RST_FRAME_HIGH;
        end else if (i_sof_valid) begin
            frame_high <= i_sof_frame[utec_pkg::FRAME_HIGH_LSB +: 3];
        end
    end

    // Stall flags: a hardware set in the same cycle as a clear wins
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_stall
            wire set_dev = i_stall_valid && !i_host_mode && (i_stall_ep == 4'(g));
            wire set_host = hw_host_stall && (o_tok.ep == 4'(g));
            wire clr = ep_write && (bus_ep == 4'(g)) && !wd[utec_pkg::FIELD_STALL];
            assign next_stall[g] = set_dev | set_host | (stall[g] & ~clr);
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            stall <= 16'h0000;
        end else begin
            stall <= next_stall;
        end
    end

    // Host token issue; writes while a transaction is open only update the register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tok_state <= utec_pkg::TOK_IDLE;
            o_tok_valid <= 1'b0;
            o_tok <= '0;
            o_tok_busy <= 1'b0;
        end else begin
            o_tok_valid <= 1'b0;
            case (tok_state)
                utec_pkg::TOK_IDLE: begin
                    if (launch) begin
                        o_tok_valid <= 1'b1;
                        o_tok.pid <= wd[utec_pkg::TOK_PID_LSB +: 4];
                        o_tok.ep <= wd[utec_pkg::TOK_EP_LSB +: 4];
                        o_tok.low_speed_direct <= ep0_low_speed_direct;
                        o_tok.use_preamble <= !ep0_low_speed_direct;
                        o_tok_busy <= 1'b1;
                        tok_state <= utec_pkg::TOK_WAIT;
                    end
                end
                utec_pkg::TOK_WAIT: begin
                    if (!i_host_mode) begin
                        o_tok_busy <= 1'b0;
                        tok_state <= utec_pkg::TOK_IDLE;
                    end else if (nak_retry) begin
                        o_tok_valid <= 1'b1;
                    end else if (i_tok_done) begin
                        o_tok_busy <= 1'b0;
                        tok_state <= utec_pkg::TOK_IDLE;
                    end
                end
                default: begin
                    o_tok_busy <= 1'b0;
                    tok_state <= utec_pkg::TOK_IDLE;
                end
            endcase
        end
    end

    // Device side: look up the endpoint, answer two cycles after the token
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rx_valid_d <= 1'b0;
            rx_pid_d <= 4'h0;
            rx_ep_d <= 4'h0;
            o_verdict <= '0;
        end else begin
            rx_valid_d <= i_rx_tok.valid && !i_host_mode;
            rx_pid_d <= i_rx_tok.pid;
            rx_ep_d <= i_rx_tok.ep;
            o_verdict.valid <= rx_valid_d;
            o_verdict.ep <= rx_ep_d;
            o_verdict.accept <= rx_valid_d && v_accept;
            o_verdict.handshake <= rx_valid_d && v_hshk;
            o_verdict.stalled <= rx_valid_d && stall[rx_ep_d];
        end
    end

endmodule

// >>> sim/utec_core_asserts.sv
// Purpose: Port checks for utec_core
// Assumes: One clock, synchronous reset
// Notes: Register contents are left to the bench
`timescale 1ns/1ps
module utec_core_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_host_mode,
    input wire logic o_tok_valid,
    input wire utec_pkg::utec_token_type o_tok,
    input wire logic i_tok_done,
    input wire logic [1:0] i_tok_result,
    input wire utec_pkg::utec_rx_token_type i_rx_tok,
    input wire utec_pkg::utec_verdict_type o_verdict,
    input wire logic o_tok_busy
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic req = i_avs_read || i_avs_write;
    wire logic ans = req && !o_avs_waitrequest;
    wire logic frm_rd = i_avs_address == utec_pkg::ADDR_FRAME_HIGH;
    wire logic tok_wr = ans && i_avs_write && i_avs_byteenable[0]
        && i_avs_address == utec_pkg::ADDR_TOKEN
        && i_host_mode && !o_tok_busy;
    wire logic rx_dev = i_rx_tok.valid && !i_host_mode;
    wire logic rsvd = i_rx_tok.pid != utec_pkg::PID_OUT && i_rx_tok.pid != utec_pkg::PID_IN
        && i_rx_tok.pid != utec_pkg::PID_SETUP;
    bus_answer_a: assert property (req |-> ##[0:3] !o_avs_waitrequest) else $error("no answer");
    answer_once_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("long answer");
    upper_zero_a: assert property (ans |-> o_avs_readdata[31:8] == 24'h00_0000
        && (!frm_rd || o_avs_readdata[7:3] == 5'h00)) else $error("upper bits set");
    token_issue_a: assert property (tok_wr |=> o_tok_valid && o_tok_busy
        && o_tok.pid == $past(i_avs_writedata[7:4]) && o_tok.ep == $past(i_avs_writedata[3:0]))
        else $error("token not issued");
    token_pulse_a: assert property (o_tok_valid |-> o_tok_busy ##1 !o_tok_valid) else $error("pulse");
    done_close_a: assert property (o_tok_busy && i_tok_done && i_tok_result != utec_pkg::RES_NAK
        |=> !o_tok_busy && !o_tok_valid) else $error("busy stuck");
    verdict_time_a: assert property (rx_dev |-> ##2 o_verdict.valid
        && o_verdict.ep == $past(i_rx_tok.ep, 2)) else $error("verdict late");
    reserved_pid_a: assert property (rx_dev && rsvd |-> ##2 !o_verdict.accept) else $error("rsvd");
    stall_block_a: assert property (o_verdict.valid && o_verdict.stalled |-> !o_verdict.accept)
        else $error("stalled accepted");
    cover property (tok_wr);
    cover property (o_tok_busy && i_tok_done && i_tok_result == utec_pkg::RES_NAK);
    cover property (o_verdict.valid && o_verdict.accept);
endmodule
bind utec_core utec_core_checker u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_host_mode(i_host_mode), .o_tok_valid(o_tok_valid),
    .o_tok(o_tok), .i_tok_done(i_tok_done), .i_tok_result(i_tok_result), .i_rx_tok(i_rx_tok),
    .o_verdict(o_verdict), .o_tok_busy(o_tok_busy));

// >>> sim/utec_link_model.sv
// Purpose: Link partner answering issued tokens
// Assumes: One transaction open at a time
// Notes: Answers three to six cycles after taking the token, NAKs first as asked
`timescale 1ns/1ps
module utec_link_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_tok_valid,
    input wire logic [3:0] i_naks,
    input wire logic [1:0] i_final,
    output logic o_tok_done,
    output logic [1:0] o_tok_result
);
    logic open = 1'b0;
    int wait_cnt = 0;
    int nak_given = 0;
    initial begin
        o_tok_done = 1'b0;
        o_tok_result = 2'h0;
    end
    always @(posedge i_clk) begin
        o_tok_done <= 1'b0;
        // Result lines wander outside the answer, nothing stale to lean on
        o_tok_result <= ~o_tok_result;
        if (!i_rst_n) begin
            open <= 1'b0;
            nak_given <= 0;
        end else if (i_tok_valid) begin
            open <= 1'b1;
            wait_cnt <= 2 + $urandom_range(3);
        end else if (open && wait_cnt > 0) begin
            wait_cnt <= wait_cnt - 1;
        end else if (open) begin
            open <= 1'b0;
            o_tok_done <= 1'b1;
            if (nak_given < i_naks) begin
                o_tok_result <= utec_pkg::RES_NAK;
                nak_given <= nak_given + 1;
            end else begin
                o_tok_result <= i_final;
                nak_given <= 0;
            end
        end
    end
endmodule

// >>> sim/tb_usb_token_endpoint_control.sv
// Purpose: Self-checking bench for utec_core
// Assumes: Link model answers issued tokens
// Notes: Expected values come from a bench model of the registers
`timescale 1ns/1ps
module tb_usb_token_endpoint_control;
    logic i_clk = 0, i_rst_n = 0, rd = 0, wr = 0, host = 1, sof = 0, stv = 0;
    logic wq, tv, busy, done;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rdat, rdd;
    logic [3:0] be = 4'hF, sep = 4'h0, naks = 4'h0, p, e;
    logic [10:0] frm = 11'h000;
    logic [1:0] fin = 2'h0, resp, tres, rsp;
    utec_pkg::utec_token_type tok, tcap;
    utec_pkg::utec_rx_token_type rx = 9'h000;
    utec_pkg::utec_verdict_type vd;
    logic [7:0] ep_m [16];
    logic [9:0] vq [$];
    int miscompares = 0, compares = 0, pulses = 0;
    always #50 i_clk = ~i_clk;
    utec_core DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wq), .o_avs_response(resp), .i_host_mode(host), .i_sof_valid(sof),
        .i_sof_frame(frm), .o_tok_valid(tv), .o_tok(tok), .i_tok_done(done), .i_tok_result(tres),
        .i_rx_tok(rx), .i_stall_valid(stv), .i_stall_ep(sep), .o_verdict(vd), .o_tok_busy(busy));
    utec_link_model u_link (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_tok_valid(tv), .i_naks(naks),
        .i_final(fin), .o_tok_done(done), .o_tok_result(tres));
    task automatic chk_reg(input string n, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic chk_evt(input string n, input logic [9:0] x, input logic [9:0] g);
        compares++;
        if (g !== x) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Holds the request until waitrequest is sampled low; watchdog bounds the wait
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge i_clk);
        while (wq !== 1'b0) @(posedge i_clk);
        rdd = rdat;
        rsp = resp;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] x);
        bus(1'b0, a, 32'h0000_0000);
        chk_reg("readdata", x, rdd);
        chk_reg("response", 32'(utec_pkg::RESP_OKAY), 32'(rsp));
    endtask
    function automatic logic [7:0] epa(input int n);
        return utec_pkg::ADDR_EP_BASE + 8'(4 * n);
    endfunction
    // Stall flag only clears on a written zero, bits 7:6 live on endpoint 0 only
    task automatic wep(input int n, input logic [31:0] d);
        bus(1'b1, epa(n), d);
        ep_m[n] = (d[7:0] & (n == 0 ? 8'hDD : 8'h1D) & 8'hFD) | (ep_m[n] & d[7:0] & 8'h02);
    endtask
    task automatic issue(input logic [3:0] tp, input logic [3:0] te, input logic [3:0] k,
                         input logic [1:0] f);
        naks <= k;
        fin <= f;
        pulses = 0;
        bus(1'b1, utec_pkg::ADDR_TOKEN, {24'($urandom), tp, te});
        while (busy !== 1'b0 || pulses == 0) @(posedge i_clk);
        chk_evt("token", {tp, te, ep_m[0][7], !ep_m[0][7]}, tcap);
        chk_reg("pulses", ep_m[0][6] ? 32'h0000_0001 : 32'(k) + 32'h0000_0001, pulses);
        if (f == utec_pkg::RES_STALL) ep_m[te][1] = 1'b1;
        rchk(utec_pkg::ADDR_TOKEN, {24'h00_0000, tp, te});
    endtask
    function automatic logic [9:0] vexp(input logic [3:0] tp, input logic [3:0] te);
        logic [7:0] r;
        logic ok;
        r = ep_m[te];
        ok = tp == utec_pkg::PID_OUT ? r[3] : tp == utec_pkg::PID_IN ? r[2] :
            tp == utec_pkg::PID_SETUP ? r[3] && !(r[2] && r[4]) : 1'b0;
        return {3'h1, te, ok && !r[1], r[0], r[1]};
    endfunction
    always @(posedge i_clk) begin
        if (tv === 1'b1) begin
            pulses++;
            tcap = tok;
        end
        if (vd.valid === 1'b1) begin
            chk_evt("verdict", vq.size() > 0 ? vq.pop_front() : 10'h3FF, {2'h0, vd});
        end
    end
    initial begin
        void'($urandom(24));
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        rchk(utec_pkg::ADDR_FRAME_HIGH, 32'h0000_0000);
        for (int n = 0; n < 16; n++) begin
            ep_m[n] = 8'h00;
            rchk(epa(n), 32'h0000_0000);
            wep(n, $urandom);
            rchk(epa(n), 32'(ep_m[n]));
        end
        bus(1'b0, 8'h20, 32'h0000_0000);
        chk_reg("unmapped", 32'(utec_pkg::RESP_DECODEERROR), 32'(rsp));
        be <= 4'h0;
        bus(1'b1, epa(2), 32'h0000_00FF);
        be <= 4'hF;
        rchk(epa(2), 32'(ep_m[2]));
        repeat (2) begin
            frm <= 11'($urandom);
            sof <= 1'b1;
            @(posedge i_clk);
            sof <= 1'b0;
            rchk(utec_pkg::ADDR_FRAME_HIGH, 32'(frm[10:8]));
        end
        wep(0, 32'h0000_0080);
        issue(utec_pkg::PID_OUT, 4'h3, 4'h2, utec_pkg::RES_ACK);
        issue(utec_pkg::PID_IN, 4'h7, 4'h0, utec_pkg::RES_STALL);
        rchk(epa(7), 32'(ep_m[7]));
        wep(0, 32'h0000_0040);
        issue(utec_pkg::PID_SETUP, 4'h1, 4'h1, utec_pkg::RES_ACK);
        issue(utec_pkg::PID_OUT, 4'h2, 4'h0, utec_pkg::RES_ERROR);
        host <= 1'b0;
        wep(5, 32'h0000_001D);
        wep(6, 32'h0000_0009);
        stv <= 1'b1;
        sep <= 4'h6;
        @(posedge i_clk);
        stv <= 1'b0;
        ep_m[6][1] = 1'b1;
        rchk(epa(6), 32'(ep_m[6]));
        for (int k = 0; k < 48; k++) begin
            p = k % 4 == 0 ? utec_pkg::PID_OUT : k % 4 == 1 ? utec_pkg::PID_IN :
                k % 4 == 2 ? utec_pkg::PID_SETUP : 4'($urandom_range(8, 2));
            e = k < 24 ? 4'(5 + k % 3) : 4'($urandom);
            rx <= {1'b1, p, e};
            vq.push_back(vexp(p, e));
            @(posedge i_clk);
        end
        rx <= 9'h000;
        repeat (4) @(posedge i_clk);
        chk_reg("pending verdicts", 32'h0000_0000, 32'(vq.size()));
        complete_run;
    end
    initial begin
        // About 20000 cycles, far beyond the few hundred the tests need
        #2000000;
        miscompares++;
        complete_run;
    end
endmodule
